// File: verilog/led_dim_pkg.sv
// constants, types and register map of the led dimming control block
// assumes a single 25 mhz system clock and a classic wishbone master
package led_dim_pkg;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] DUTY_OFS   = 8'h08;
	localparam logic [7:0] FRAME_OFS  = 8'h0c;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int          CTRL_OUT_EN_BIT   = 0;
	localparam logic [31:0] CTRL_RESET        = 32'h0000_0001;
	localparam int          STAT_MODE_LSB     = 0;
	localparam int          STAT_TEST_LSB     = 2;
	localparam int          STAT_DISABLED_LSB = 8;
	localparam int          STAT_BITS_LSB     = 16;
	localparam logic [31:0] DUTY_RESET        = 32'h0000_0000;

	// ----------------------------------------
	// timing counts; pwm steps, frame bits, and dc sample and test counts in system clocks
	// ----------------------------------------
	localparam int PWM_STEPS         = 256;
	localparam int FRAME_BITS        = 32;
	localparam int DC_SAMPLE_CYCLES  = 1280;
	localparam int LED_TEST_CYCLES   = 2500;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_DIRECT = 2'b00,
		MODE_SERIAL = 2'b01,
		MODE_DC     = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		TEST_IDLE = 2'b00,
		TEST_RUN  = 2'b01,
		TEST_DONE = 2'b11
	} test_e;

	typedef logic [3:0][7:0] duty_set_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

endpackage

// File: verilog/led_dim_ctrl.sv
// dimming control for a six channel linear led driver, all logic
// assumes every input is synchronous to clk_i and rst_i is the restart
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - mode strap at ground selects direct pwm: group inputs gate their channels
// - strap left open selects serial mode on group a, b and c inputs
// - strap at supply selects dc mode: converted group voltages give duty
// - channels 0,1 group a; 2,3 group b; 4 group c; 5 group d
// - an undriven group input reads low, so in direct mode its leds stay off
// - direct mode inputs are active high: high conducts, low is off
// - serial: group a is data, group b bit clock, group c frame end
// - a frame holds four duty bytes, first byte group a to fourth group d
// - one data bit is taken on each rising edge of the bit clock
// - frame end falling edge after 32 bits loads the four buffered bytes
// - code 00 gives 0 percent, ff gives 100, others but 02 code plus one steps
// - codes 01 and 02 both give two steps of 256
// - the pwm period is 256 cycles of the output clock
// - the output clock pin toggles on every system clock, so it runs at half the system clock rate
// - rail sense reaching threshold starts a timed string test with test current
// - a channel sensed low during the test is latched off and leaves headroom control
// - the string test runs once per start-up only
// - latched disables clear only on restart
module led_dim_ctrl #(
	parameter int TEST_CYCLES = led_dim_pkg::LED_TEST_CYCLES,
	parameter int DC_SAMPLE   = led_dim_pkg::DC_SAMPLE_CYCLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire led_dim_pkg::wb_req_s  wb_req_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [1:0]            mode_strap_i,
	input  wire logic                  group_a_dim_input_i,
	input  wire logic                  group_b_dim_input_i,
	input  wire logic                  group_c_dim_input_i,
	input  wire logic                  group_d_dim_input_i,
	input  wire logic [3:0]            group_driven_i,
	input  wire led_dim_pkg::duty_set_t dc_duty_i,
	input  wire logic                  rail_feedback_sense_i,
	input  wire logic [5:0]            drain_sense_low_i,
	output logic                       half_rate_clock_output_o,
	output logic [5:0]                 test_current_o,
	output logic [5:0]                 channel_on_o,
	output logic [5:0]                 headroom_exclude_o
);

	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	if (TEST_CYCLES < 1 || TEST_CYCLES > 65535) begin : g_bad_test
		$error("TEST_CYCLES out of range");
	end
	if (DC_SAMPLE < 2 || DC_SAMPLE > 65535) begin : g_bad_dc
		$error("DC_SAMPLE out of range");
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	led_dim_pkg::mode_e     mode_q;
	logic                   strap_taken_q;
	led_dim_pkg::test_e     test_q;
	logic [15:0]            test_cnt_q;
	logic [5:0]             disabled_q;
	logic                   half_clk_q;
	logic [7:0]             pwm_cnt_q;
	logic [15:0]            dc_cnt_q;
	logic [31:0]            shift_q;
	logic [5:0]             bit_cnt_q;
	logic                   sclk_prev_q;
	logic                   eof_prev_q;
	led_dim_pkg::duty_set_t duty_q;
	logic [31:0]            ctrl_q;
	logic [31:0]            rd_dat_q;
	logic                   ack_q;
	logic [3:0]             grp_in;
	logic [3:0]             grp_pwm;
	logic [3:0]             grp_on;
	logic                   wb_hit;
	logic                   bclk_rise;
	logic                   eof_fall;
	logic                   out_en;
	logic [5:0]             ch_next;

	// undriven inputs read as the pull-down level
	assign grp_in = {group_d_dim_input_i, group_c_dim_input_i,
	                 group_b_dim_input_i, group_a_dim_input_i} & group_driven_i;

	// ----------------------------------------
	// mode strap, caught once after restart
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_taken_q <= 1'b0;
			mode_q        <= led_dim_pkg::MODE_DIRECT;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			unique case (mode_strap_i)
				2'b00:   mode_q <= led_dim_pkg::MODE_DIRECT;
				2'b11:   mode_q <= led_dim_pkg::MODE_DC;
				default: mode_q <= led_dim_pkg::MODE_SERIAL;
			endcase
		end
	end

	// ----------------------------------------
	// output clock and shared pwm counter
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			half_clk_q <= 1'b0;
		end else begin
			half_clk_q <= ~half_clk_q;
		end
	end

	// one step per output clock period, wraps every 256 steps
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_cnt_q <= 8'h00;
		end else if (half_clk_q) begin
			pwm_cnt_q <= pwm_cnt_q + 8'h01;
		end
	end

	// ----------------------------------------
	// serial frame receiver
	// ----------------------------------------
	// bit clock and frame end sampled directly; the source is assumed slow
	// against clk_i, so a glitch shorter than a cycle is simply missed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_prev_q <= 1'b0;
			eof_prev_q  <= 1'b0;
		end else begin
			sclk_prev_q <= grp_in[1];
			eof_prev_q  <= grp_in[2];
		end
	end

	assign bclk_rise = grp_in[1] && !sclk_prev_q;
	assign eof_fall  = eof_prev_q && !grp_in[2];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_q   <= 32'h0000_0000;
			bit_cnt_q <= 6'd0;
		end else if (mode_q == led_dim_pkg::MODE_SERIAL) begin
			if (eof_fall) begin
				bit_cnt_q <= 6'd0;
			end else if (bclk_rise) begin
				shift_q <= {shift_q[30:0], grp_in[0]};
				if (bit_cnt_q != 6'(led_dim_pkg::FRAME_BITS)) begin
					bit_cnt_q <= bit_cnt_q + 6'd1;
				end
			end
		end
	end

	// ----------------------------------------
	// duty settings
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dc_cnt_q <= 16'h0000;
		end else if (dc_cnt_q == 16'(DC_SAMPLE - 1)) begin
			dc_cnt_q <= 16'h0000;
		end else begin
			dc_cnt_q <= dc_cnt_q + 16'h0001;
		end
	end

	// a short frame is dropped rather than loaded half-filled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			duty_q <= led_dim_pkg::DUTY_RESET;
		end else if (mode_q == led_dim_pkg::MODE_SERIAL) begin
			if (eof_fall && bit_cnt_q == 6'(led_dim_pkg::FRAME_BITS)) begin
				duty_q <= {shift_q[7:0], shift_q[15:8], shift_q[23:16], shift_q[31:24]};
			end
		end else if (mode_q == led_dim_pkg::MODE_DC && dc_cnt_q == 16'h0000) begin
			duty_q <= dc_duty_i;
		end
	end

	// ----------------------------------------
	// per group threshold compare
	// ----------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_grp
		logic [8:0] thr;
		always_comb begin
			if (duty_q[g] == 8'h00) begin
				thr = 9'd0;
			end else if (duty_q[g] == 8'h01 || duty_q[g] == 8'h02) begin
				thr = 9'd2;
			end else begin
				thr = {1'b0, duty_q[g]} + 9'd1;
			end
		end
		assign grp_pwm[g] = {1'b0, pwm_cnt_q} < thr;
		assign grp_on[g]  = (mode_q == led_dim_pkg::MODE_DIRECT) ? grp_in[g] : grp_pwm[g];
	end

	// ----------------------------------------
	// start-up led string test
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			test_q     <= led_dim_pkg::TEST_IDLE;
			test_cnt_q <= 16'h0000;
		end else begin
			unique case (test_q)
				led_dim_pkg::TEST_IDLE: begin
					if (rail_feedback_sense_i) begin
						test_q <= led_dim_pkg::TEST_RUN;
					end
				end
				led_dim_pkg::TEST_RUN: begin
					if (test_cnt_q == 16'(TEST_CYCLES - 1)) begin
						test_q <= led_dim_pkg::TEST_DONE;
					end else begin
						test_cnt_q <= test_cnt_q + 16'h0001;
					end
				end
				led_dim_pkg::TEST_DONE: begin
					test_q <= led_dim_pkg::TEST_DONE;
				end
				// the unused code falls to done, never into a second test
				default: begin
					test_q <= led_dim_pkg::TEST_DONE;
				end
			endcase
		end
	end

	// only a restart clears a latched disable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disabled_q <= 6'b00_0000;
		end else if (test_q == led_dim_pkg::TEST_RUN) begin
			disabled_q <= disabled_q | drain_sense_low_i;
		end
	end

	// ----------------------------------------
	// channel outputs
	// ----------------------------------------
	// channels stay dark until the string test is over and outputs are enabled
	assign out_en = test_q == led_dim_pkg::TEST_DONE && ctrl_q[led_dim_pkg::CTRL_OUT_EN_BIT];

	for (genvar c = 0; c < 6; c++) begin : g_ch
		localparam int GRP = (c < 4) ? c / 2 : c - 2;
		assign ch_next[c] = out_en && !disabled_q[c] && grp_on[GRP];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_on_o <= 6'b00_0000;
		end else begin
			channel_on_o <= ch_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			half_rate_clock_output_o <= 1'b0;
		end else begin
			half_rate_clock_output_o <= half_clk_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			test_current_o <= 6'b00_0000;
		end else begin
			test_current_o <= {6{test_q == led_dim_pkg::TEST_RUN}};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			headroom_exclude_o <= 6'b00_0000;
		end else begin
			headroom_exclude_o <= disabled_q;
		end
	end

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !ack_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= led_dim_pkg::CTRL_RESET;
		end else if (wb_hit && wb_req_i.we && wb_req_i.adr == led_dim_pkg::CTRL_OFS && wb_req_i.sel[0]) begin
			ctrl_q <= {31'h0000_0000, wb_req_i.dat[led_dim_pkg::CTRL_OUT_EN_BIT]};
		end
	end

	// one cycle answer; a request still held in the ack cycle is not taken twice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_hit;
		end
	end

	// unmapped addresses answer zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_dat_q <= 32'h0000_0000;
		end else begin
			rd_dat_q <= 32'h0000_0000;
			if (wb_hit && !wb_req_i.we) begin
				unique case (wb_req_i.adr)
					led_dim_pkg::CTRL_OFS:   rd_dat_q <= ctrl_q;
					led_dim_pkg::STATUS_OFS: begin
						rd_dat_q[led_dim_pkg::STAT_MODE_LSB +: 2]     <= mode_q;
						rd_dat_q[led_dim_pkg::STAT_TEST_LSB +: 2]     <= test_q;
						rd_dat_q[led_dim_pkg::STAT_DISABLED_LSB +: 6] <= disabled_q;
						rd_dat_q[led_dim_pkg::STAT_BITS_LSB +: 6]     <= bit_cnt_q;
					end
					led_dim_pkg::DUTY_OFS:   rd_dat_q <= duty_q;
					led_dim_pkg::FRAME_OFS:  rd_dat_q <= shift_q;
					default:                 rd_dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rd_dat_q;

endmodule

`default_nettype wire

// File: verif/led_dim_ctrl_properties.sv
// port assertions for the led dimming control block
// bound to every led_dim_ctrl instance, single clock domain
`timescale 1ns/100ps
`default_nettype none
module led_dim_props #(
	parameter int TEST_CYCLES = 20,
	parameter int DC_SAMPLE   = 16
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire led_dim_pkg::wb_req_s   wb_req_i,
	input  wire logic [31:0]            wb_dat_o,
	input  wire logic                   wb_ack_o,
	input  wire logic [1:0]             mode_strap_i,
	input  wire logic                   group_a_dim_input_i,
	input  wire logic                   group_b_dim_input_i,
	input  wire logic                   group_c_dim_input_i,
	input  wire logic                   group_d_dim_input_i,
	input  wire logic [3:0]             group_driven_i,
	input  wire led_dim_pkg::duty_set_t dc_duty_i,
	input  wire logic                   rail_feedback_sense_i,
	input  wire logic [5:0]             drain_sense_low_i,
	input  wire logic                   half_rate_clock_output_o,
	input  wire logic [5:0]             test_current_o,
	input  wire logic [5:0]             channel_on_o,
	input  wire logic [5:0]             headroom_exclude_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic tst_q;
	logic done_q;
	// done_q marks the end of the one string test of this start-up
	always_ff @(posedge clk_i) begin
		tst_q  <= rst_i ? 1'b0 : |test_current_o;
		done_q <= rst_i ? 1'b0 : (done_q | (tst_q & ~|test_current_o));
	end
	chk_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("wishbone request not acked next cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_clk_half: assert property (half_rate_clock_output_o |=> !half_rate_clock_output_o)
		else $error("output clock high two cycles");
	chk_clk_rise: assert property (!$past(rst_i) && !half_rate_clock_output_o |=> half_rate_clock_output_o)
		else $error("output clock low two cycles");
	chk_test_all: assert property (|test_current_o |-> test_current_o == 6'h3f)
		else $error("test current not on all channels");
	chk_test_once: assert property (done_q |-> test_current_o == 6'h00)
		else $error("string test repeated");
	// done_q lags the end of the test by a cycle, so that cycle is left out
	chk_untested_off: assert property (!done_q && !(tst_q && test_current_o == 6'h00)
		|-> channel_on_o == 6'h00)
		else $error("channel on before test done");
	chk_latch_kept: assert property ((~headroom_exclude_o & $past(headroom_exclude_o)) == 6'h00)
		else $error("latched disable cleared without restart");
	chk_excl_off: assert property ((channel_on_o & headroom_exclude_o) == 6'h00)
		else $error("disabled channel conducting");
	chk_direct_low: assert property (mode_strap_i == 2'b00 && !group_b_dim_input_i
		|=> channel_on_o[3:2] == 2'b00)
		else $error("group b channels on with input low");
	cover property (wb_ack_o && wb_req_i.we);
	cover property ($fell(tst_q));
	cover property (mode_strap_i == 2'b01 && $fell(group_c_dim_input_i));
endmodule
bind led_dim_ctrl led_dim_props #(.TEST_CYCLES(TEST_CYCLES), .DC_SAMPLE(DC_SAMPLE)) u_props (.*);
`default_nettype wire

// File: verif/serial_dim_model.sv
// external dimming controller driving the serial group inputs
// assumes the caller invokes send just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module serial_dim_model (
	input  wire logic clk_i,
	output logic      data_o,
	output logic      bclk_o,
	output logic      eof_o
);
	initial begin
		data_o = 1'b0;
		bclk_o = 1'b0;
		eof_o  = 1'b0;
	end
	// two clocks per level, more than the one clock the block needs; it sets no upper limit
	task automatic hold2();
		repeat (2) @(posedge clk_i);
	endtask
	task automatic send(input logic [31:0] frame, input int nbits);
		for (int i = 0; i < nbits; i++) begin
			data_o <= frame[31 - i];
			hold2();
			bclk_o <= 1'b1;
			hold2();
			bclk_o <= 1'b0;
		end
		data_o <= 1'b0; // released line reads as pulled low
		eof_o  <= 1'b1;
		hold2();
		eof_o  <= 1'b0;
		hold2();
		hold2();
	endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for led_dim_ctrl in all three strap modes
// assumes the serial model and the bound property checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb;
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	led_dim_pkg::wb_req_s   wb_req = '0;
	logic [31:0]            wb_dat;
	logic                   wb_ack;
	logic [1:0]             strap = 2'b00;
	logic [3:0]             dir = 4'h0;
	logic [3:0]             driven = 4'hf;
	led_dim_pkg::duty_set_t dc_duty = '0;
	logic                   rail = 1'b0;
	logic [5:0]             dsl = 6'h00;
	logic [5:0]             tcur, ch_on, excl;
	logic                   s_dat, s_clk, s_eof;
	logic [31:0]            rd;
	logic [9:0]             cnt [6];
	logic [31:0]            fr [2] = '{32'h00ff_0180, 32'h0102_fe7f};
	int                     gmap [6] = '{0, 0, 1, 1, 2, 3};
	int                     errors = 0;
	int                     cmp_count = 0;
	always #20 clk_i = ~clk_i;
	led_dim_ctrl #(.TEST_CYCLES(20), .DC_SAMPLE(16)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
		.mode_strap_i(strap), .group_a_dim_input_i(dir[0] | s_dat), .group_b_dim_input_i(dir[1] | s_clk),
		.group_c_dim_input_i(dir[2] | s_eof), .group_d_dim_input_i(dir[3]), .group_driven_i(driven),
		.dc_duty_i(dc_duty), .rail_feedback_sense_i(rail), .drain_sense_low_i(dsl),
		.half_rate_clock_output_o(), .test_current_o(tcur), .channel_on_o(ch_on), .headroom_exclude_o(excl));
	serial_dim_model u_ser (.clk_i(clk_i), .data_o(s_dat), .bclk_o(s_clk), .eof_o(s_eof));
	task automatic wrap_up();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
		n = 0;
		do begin @(posedge clk_i); n++; end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin errors++; wrap_up(); end
		rd = wb_dat;
		wb_req <= '0;
		@(posedge clk_i);
	endtask
	task automatic restart(input logic [1:0] m);
		strap <= m;
		rail <= 1'b0;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic run_test();
		int n;
		rail <= 1'b1;
		n = 0;
		while (tcur !== 6'h3f && n < 100) begin @(posedge clk_i); n++; end
		while (tcur !== 6'h00 && n < 100) begin @(posedge clk_i); n++; end
		if (n >= 100) begin errors++; wrap_up(); end
		repeat (3) @(posedge clk_i);
	endtask
	// one full pwm period is 512 system clocks, so counts are exact
	task automatic measure();
		for (int k = 0; k < 6; k++) cnt[k] = '0;
		repeat (512) begin
			@(posedge clk_i);
			for (int k = 0; k < 6; k++) cnt[k] = cnt[k] + ch_on[k];
		end
	endtask
	function automatic logic [9:0] steps(input logic [7:0] c);
		return (c == 8'h00) ? 10'd0 : (c == 8'h01 || c == 8'h02) ? 10'd4 : 10'(2 * (c + 1));
	endfunction
	initial begin
		// ----------------------------------------
		// direct mode
		// ----------------------------------------
		restart(2'b00);
		dsl <= 6'h20;
		run_test();
		`CHK("excl", 6'h20, excl)
		wb(1'b0, led_dim_pkg::STATUS_OFS, 32'h0);
		`CHK("status", 32'h0000_200c, rd)
		dir <= 4'b1101;
		repeat (200) @(posedge clk_i);
		`CHK("direct_on", 6'b010011, ch_on)
		driven <= 4'b1100;
		repeat (3) @(posedge clk_i);
		`CHK("pulled_low", 6'b010000, ch_on)
		wb(1'b1, led_dim_pkg::CTRL_OFS, 32'h0);
		wb(1'b0, led_dim_pkg::CTRL_OFS, 32'h0);
		`CHK("ctrl", 32'h0, rd)
		wb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		dsl <= 6'h3f;
		rail <= 1'b0;
		repeat (3) @(posedge clk_i);
		rail <= 1'b1;
		repeat (30) @(posedge clk_i);
		`CHK("retest", 6'h00, tcur)
		`CHK("excl_kept", 6'h20, excl)
		// ----------------------------------------
		// serial mode, then dc mode
		// ----------------------------------------
		restart(2'b01);
		dsl <= 6'h00;
		driven <= 4'hf;
		dir <= 4'h0;
		run_test();
		for (int f = 0; f < 2; f++) begin
			u_ser.send(fr[f], 32);
			wb(1'b0, led_dim_pkg::DUTY_OFS, 32'h0);
			`CHK("duty", {fr[f][7:0], fr[f][15:8], fr[f][23:16], fr[f][31:24]}, rd)
			measure();
			for (int k = 0; k < 6; k++) `CHK("on_steps", steps(fr[f][31 - 8 * gmap[k] -: 8]), cnt[k])
		end
		u_ser.send(32'hffff_ffff, 16);
		wb(1'b0, led_dim_pkg::DUTY_OFS, 32'h0);
		`CHK("short_frame", 32'h7ffe_0201, rd)
		wb(1'b0, led_dim_pkg::FRAME_OFS, 32'h0);
		`CHK("frame_raw", 32'hfe7f_ffff, rd)
		restart(2'b11);
		dc_duty <= {8'h40, 8'h30, 8'h20, 8'h10};
		run_test();
		repeat (40) @(posedge clk_i);
		wb(1'b0, led_dim_pkg::DUTY_OFS, 32'h0);
		`CHK("dc_duty", 32'h4030_2010, rd)
		wrap_up();
	end
endmodule
`default_nettype wire
